// [core/cdrpd_top.sv]
`include "cdrpd_defines.svh"
module cdrpd_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Serial line samples
  input wire logic mid_sample_i,
  input wire logic edge_sample_i,
  input wire logic bit_strobe_i,
  // Loop status
  input wire logic freq_lock_i,
  input wire logic phase_lock_i,
  input wire logic acq_enable_i,
  // Recovered data
  output logic data_o,
  output logic data_valid_o,
  // Phase decision
  output logic early_o,
  output logic late_o,
  output logic lin_error_o,
  output logic lin_ref_o,
  // Loop control
  output logic freq_loop_sel_o,
  output logic phase_loop_sel_o,
  output logic locked_o
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_q, rst_s2_q, rst_n;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Three stages; a change counts when stages two and three agree
  logic [2:0] mid_q, edg_q, stb_q, fl_q, pl_q;
  logic [2:0] mid_d, edg_d, stb_d, fl_d, pl_d;
  logic mid_f_q, edg_f_q, stb_f_q, fl_f_q, pl_f_q;
  logic mid_f_d, edg_f_d, stb_f_d, fl_f_d, pl_f_d;

  function automatic logic cdrpd_filt(input logic [2:0] s, input logic prev);
    cdrpd_filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction : cdrpd_filt

  always_comb begin
    mid_d = {mid_q[1:0], mid_sample_i};
    edg_d = {edg_q[1:0], edge_sample_i};
    stb_d = {stb_q[1:0], bit_strobe_i};
    fl_d = {fl_q[1:0], freq_lock_i};
    pl_d = {pl_q[1:0], phase_lock_i};
    mid_f_d = cdrpd_filt(mid_q, mid_f_q);
    edg_f_d = cdrpd_filt(edg_q, edg_f_q);
    stb_f_d = cdrpd_filt(stb_q, stb_f_q);
    fl_f_d = cdrpd_filt(fl_q, fl_f_q);
    pl_f_d = cdrpd_filt(pl_q, pl_f_q);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mid_q <= 3'h0;
      edg_q <= 3'h0;
      stb_q <= 3'h0;
      fl_q <= 3'h0;
      pl_q <= 3'h0;
      mid_f_q <= 1'b0;
      edg_f_q <= 1'b0;
      stb_f_q <= 1'b0;
      fl_f_q <= 1'b0;
      pl_f_q <= 1'b0;
    end else begin
      mid_q <= mid_d;
      edg_q <= edg_d;
      stb_q <= stb_d;
      fl_q <= fl_d;
      pl_q <= pl_d;
      mid_f_q <= mid_f_d;
      edg_f_q <= edg_f_d;
      stb_f_q <= stb_f_d;
      fl_f_q <= fl_f_d;
      pl_f_q <= pl_f_d;
    end
  end

  // ----------------------------------------
  // Sample history
  // ----------------------------------------
  // Strobe rise marks one recovered bit period; edge sample is taken at the same strobe rise as the mid sample
  logic stb_prev_q, stb_prev_d, bit_tick;
  logic prev_q, prev_d, cur_q, cur_d, trans_q, trans_d, hist_ok_q, hist_ok_d;
  logic tick_q, tick_d, dout_q, dout_d;
  assign bit_tick = stb_f_q && !stb_prev_q;

  always_comb begin
    stb_prev_d = stb_f_q;
    prev_d = prev_q;
    cur_d = cur_q;
    trans_d = trans_q;
    hist_ok_d = hist_ok_q;
    tick_d = 1'b0;
    dout_d = dout_q;
    if (bit_tick) begin
      prev_d = cur_q;
      cur_d = mid_f_q;
      trans_d = edg_f_q;
      hist_ok_d = 1'b1;
      tick_d = hist_ok_q;
      dout_d = mid_f_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      stb_prev_q <= 1'b0;
      prev_q <= 1'b0;
      cur_q <= 1'b0;
      trans_q <= 1'b0;
      hist_ok_q <= 1'b0;
      tick_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      stb_prev_q <= stb_prev_d;
      prev_q <= prev_d;
      cur_q <= cur_d;
      trans_q <= trans_d;
      hist_ok_q <= hist_ok_d;
      tick_q <= tick_d;
      dout_q <= dout_d;
    end
  end
  assign data_o = dout_q;
  assign data_valid_o = tick_q;

  // ----------------------------------------
  // Phase detectors
  // ----------------------------------------
  // edge and mid samples per bit
  cdrpd_bb_det u_bb (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .previous_bit_sample_i(prev_q),
    .transition_time_sample_i(trans_q),
    .current_bit_sample_i(cur_q),
    .sample_valid_i(tick_q),
    .early_o(early_o),
    .late_o(late_o)
  );

  cdrpd_lin_det u_lin (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .data_i(mid_f_q),
    .retimed_i(dout_q),
    .lin_error_o(lin_error_o),
    .lin_ref_o(lin_ref_o)
  );

  // ----------------------------------------
  // Acquisition controller
  // ----------------------------------------
  cdrpd_pkg::cdrpd_acq_e st_q, st_d;
  logic [`CDRPD_CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      cdrpd_pkg::CDRPD_ACQ_RESET: begin
        cnt_d = `CDRPD_CNT_ZERO;
        if (acq_enable_i) begin
          st_d = cdrpd_pkg::CDRPD_ACQ_FREQ;
        end
      end
      cdrpd_pkg::CDRPD_ACQ_FREQ: begin
        if (!fl_f_q) begin
          cnt_d = `CDRPD_CNT_ZERO;
        end else if (cnt_q == `CDRPD_LOCK_CNT) begin
          st_d = cdrpd_pkg::CDRPD_ACQ_PHASE;
          cnt_d = `CDRPD_CNT_ZERO;
        end else begin
          cnt_d = cnt_q + `CDRPD_CNT_ONE;
        end
      end
      cdrpd_pkg::CDRPD_ACQ_PHASE: begin
        if (!fl_f_q || !pl_f_q) begin
          if (cnt_q == `CDRPD_LOSS_CNT) begin
            st_d = cdrpd_pkg::CDRPD_ACQ_FREQ;
            cnt_d = `CDRPD_CNT_ZERO;
          end else begin
            cnt_d = cnt_q + `CDRPD_CNT_ONE;
          end
        end else begin
          cnt_d = `CDRPD_CNT_ZERO;
        end
      end
      default: begin
        st_d = cdrpd_pkg::CDRPD_ACQ_RESET;
        cnt_d = `CDRPD_CNT_ZERO;
      end
    endcase
    if (!acq_enable_i) begin
      st_d = cdrpd_pkg::CDRPD_ACQ_RESET;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cdrpd_pkg::CDRPD_ACQ_RESET;
      cnt_q <= `CDRPD_CNT_ZERO;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign freq_loop_sel_o = (st_q != cdrpd_pkg::CDRPD_ACQ_PHASE);
  assign phase_loop_sel_o = (st_q == cdrpd_pkg::CDRPD_ACQ_PHASE);
  assign locked_o = (st_q == cdrpd_pkg::CDRPD_ACQ_PHASE) && pl_f_q;

  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  // Own run counters, so checks do not lean on the controller's counter
  logic [`CDRPD_CNT_W-1:0] lock_run_q, lock_run_d, loss_run_q, loss_run_d;

  always_comb begin
    lock_run_d = `CDRPD_CNT_ZERO;
    loss_run_d = `CDRPD_CNT_ZERO;
    if ((st_q == cdrpd_pkg::CDRPD_ACQ_FREQ) && fl_f_q) begin
      lock_run_d = lock_run_q + `CDRPD_CNT_ONE;
    end
    if (phase_loop_sel_o && (!fl_f_q || !pl_f_q)) begin
      loss_run_d = loss_run_q + `CDRPD_CNT_ONE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_run_q <= `CDRPD_CNT_ZERO;
      loss_run_q <= `CDRPD_CNT_ZERO;
    end else begin
      lock_run_q <= lock_run_d;
      loss_run_q <= loss_run_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_loop_excl: assert property (@(posedge mclk_i) disable iff (!rst_n) freq_loop_sel_o != phase_loop_sel_o)
    else $error("loop select not exclusive");
  a_handover_lock: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(phase_loop_sel_o) |-> $past(fl_f_q))
    else $error("handover without frequency lock");
  a_freq_first: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $past(st_q) == cdrpd_pkg::CDRPD_ACQ_RESET |-> !phase_loop_sel_o)
    else $error("phase loop before frequency loop");
  a_loss_relock: assert property (@(posedge mclk_i) disable iff (!rst_n)
    phase_loop_sel_o |-> loss_run_q <= `CDRPD_LOSS_CNT)
    else $error("no reacquire after loss");
  a_loss_count: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $fell(phase_loop_sel_o) && $past(acq_enable_i) |-> loss_run_q == `CDRPD_LOSS_CNT + `CDRPD_CNT_ONE)
    else $error("fallback without full loss run");
  a_lock_qualify: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(phase_loop_sel_o) |-> lock_run_q == `CDRPD_LOCK_CNT + `CDRPD_CNT_ONE)
    else $error("handover before lock qualified");
  a_valid_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n)
    data_valid_o |=> !data_valid_o)
    else $error("bit decision longer than one cycle");
  a_first_prime: assert property (@(posedge mclk_i) disable iff (!rst_n)
    bit_tick && !hist_ok_q |=> !data_valid_o)
    else $error("decision from unprimed history");
  a_mid_filter: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mid_q[1] != mid_q[2] |=> $stable(mid_f_q))
    else $error("sample moved before stages agreed");
  a_data_regen: assert property (@(posedge mclk_i) disable iff (!rst_n)
    bit_tick |=> data_o == $past(mid_f_q))
    else $error("regenerated bit wrong");
  a_three_samp: assert property (@(posedge mclk_i) disable iff (!rst_n)
    bit_tick |=> prev_q == $past(cur_q) && trans_q == $past(edg_f_q))
    else $error("sample history wrong");
  c_locked: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(locked_o));
  c_relock: cover property (@(posedge mclk_i) disable iff (!rst_n) $fell(phase_loop_sel_o));
  c_freq_drop: cover property (@(posedge mclk_i) disable iff (!rst_n) phase_loop_sel_o && !fl_f_q);
endmodule : cdrpd_top

// [core/cdrpd_defines.svh]
`ifndef CDRPD_DEFINES_SVH
`define CDRPD_DEFINES_SVH
// Behaviour
// - Sample mid-bit and transition; use three samples.
// - Decision outputs are binary, never proportional.
// - Equal mid-bit samples give hold decision.
// - Transition sample picks early or late.
// - Linear variant gives pulse width proportional.
// - Recovered clock regenerates data, one per bit.
// - Frequency loop steers first, phase loop after.
// - Lock detector hands control to phase loop.
// - Controller watches both loops, switches control.
// - Reacquire at start-up and after lock loss.
// - Opposite clock edges: transition and mid-bit; the code takes both at the same bit strobe, on rising mclk_i only.

// ----------------------------------------
// Acquisition timing
// ----------------------------------------
`define CDRPD_CNT_W 8
`define CDRPD_LOCK_CNT 8'h40
`define CDRPD_LOSS_CNT 8'h20
`define CDRPD_CNT_ZERO 8'h00
`define CDRPD_CNT_ONE 8'h01
`endif

// [core/cdrpd_pkg.sv]
package cdrpd_pkg;
  typedef enum logic [1:0] {
    CDRPD_ACQ_RESET,
    CDRPD_ACQ_FREQ,
    CDRPD_ACQ_PHASE
  } cdrpd_acq_e;
endpackage : cdrpd_pkg

// [core/cdrpd_bb_det.sv]
`include "cdrpd_defines.svh"
module cdrpd_bb_det (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Samples
  input wire logic previous_bit_sample_i,
  input wire logic transition_time_sample_i,
  input wire logic current_bit_sample_i,
  input wire logic sample_valid_i,
  // Decision
  output logic early_o,
  output logic late_o
);
  logic early_q, early_d, late_q, late_d;

  function automatic logic [1:0] cdrpd_decide(input logic p, input logic t, input logic c);
    if (p == c) begin
      cdrpd_decide = 2'h0;
    end else if (t == p) begin
      cdrpd_decide = 2'h2;
    end else begin
      cdrpd_decide = 2'h1;
    end
  endfunction : cdrpd_decide

  always_comb begin
    early_d = early_q;
    late_d = late_q;
    if (sample_valid_i) begin
      {early_d, late_d} = cdrpd_decide(previous_bit_sample_i, transition_time_sample_i, current_bit_sample_i);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      early_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      early_q <= early_d;
      late_q <= late_d;
    end
  end
  assign early_o = early_q;
  assign late_o = late_q;

  a_excl_flags: assert property (@(posedge mclk_i) disable iff (!rst_n_i) !(early_o && late_o))
    else $error("early and late both high");
  a_hold_equal: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sample_valid_i && (previous_bit_sample_i == current_bit_sample_i) |=> !early_o && !late_o)
    else $error("hold not given");
  a_early_dec: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sample_valid_i && (previous_bit_sample_i != current_bit_sample_i)
    && (transition_time_sample_i == previous_bit_sample_i) |=> early_o)
    else $error("early missed");
  a_late_dec: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sample_valid_i && (previous_bit_sample_i != current_bit_sample_i)
    && (transition_time_sample_i == current_bit_sample_i) |=> late_o)
    else $error("late missed");
  a_hold_between: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !sample_valid_i |=> $stable(early_o) && $stable(late_o))
    else $error("flags moved without bit");
  c_early: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(early_o));
  c_late: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(late_o));
endmodule : cdrpd_bb_det

// [core/cdrpd_lin_det.sv]
module cdrpd_lin_det (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Samples
  input wire logic data_i,
  input wire logic retimed_i,
  // Proportional error pulses
  output logic lin_error_o,
  output logic lin_ref_o
);
  logic err_q, err_d, ref_q, ref_d;

  always_comb begin
    err_d = data_i ^ retimed_i;
    ref_d = retimed_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      err_q <= err_d;
      ref_q <= ref_d;
    end
  end
  assign lin_error_o = err_q;
  assign lin_ref_o = ref_q ^ retimed_i;

  a_lin_err: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    lin_error_o == $past(data_i ^ retimed_i))
    else $error("linear error wrong");
endmodule : cdrpd_lin_det

// [tb/cdrpd_tx_model.sv]
module cdrpd_tx_model (
  // Clock
  input wire logic mclk_i,
  // Line samples
  output logic mid_sample_o,
  output logic edge_sample_o,
  output logic bit_strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    mid_sample_o = 1'b0;
    edge_sample_o = 1'b0;
    bit_strobe_o = 1'b0;
  end

  task automatic send_bit(input logic mid, input logic trans);
    @(posedge mclk_i);
    #1;
    mid_sample_o = mid;
    edge_sample_o = trans;
    repeat (4) @(posedge mclk_i);
    #1;
    bit_strobe_o = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1;
    bit_strobe_o = 1'b0;
    // Hold time over: lines flip so stale values cannot pass
    mid_sample_o = ~mid;
    edge_sample_o = ~trans;
    repeat (4) @(posedge mclk_i);
  endtask : send_bit
endmodule : cdrpd_tx_model

// [tb/cdr_phase_decision_and_acquisition_bench.sv]
module cdr_phase_decision_and_acquisition_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mid_s, edge_s, strobe;
  logic freq_lock = 1'b0;
  logic phase_lock = 1'b0;
  logic acq_en = 1'b0;
  logic data, data_valid, early, late, lin_err, lin_ref, fsel, psel, locked;
  logic prev_bit = 1'b0;
  logic [31:0] rnd;
  int fail_count = 0;
  int cmp_count = 0;
  int valid_seen = 0;
  int nbits = 0;
  int ref_seen = 0;
  int ref_exp = 0;
  integer seed = 32'hBFF64671;

  always #2.5 mclk_i = ~mclk_i;

  cdrpd_tx_model tx_u (
    .mclk_i(mclk_i),
    .mid_sample_o(mid_s),
    .edge_sample_o(edge_s),
    .bit_strobe_o(strobe)
  );

  cdrpd_top dut_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .mid_sample_i(mid_s),
    .edge_sample_i(edge_s),
    .bit_strobe_i(strobe),
    .freq_lock_i(freq_lock),
    .phase_lock_i(phase_lock),
    .acq_enable_i(acq_en),
    .data_o(data),
    .data_valid_o(data_valid),
    .early_o(early),
    .late_o(late),
    .lin_error_o(lin_err),
    .lin_ref_o(lin_ref),
    .freq_loop_sel_o(fsel),
    .phase_loop_sel_o(psel),
    .locked_o(locked)
  );

  always @(posedge mclk_i) begin
    if (data_valid === 1'b1) begin
      valid_seen++;
    end
    if (lin_ref === 1'b1) begin
      ref_seen++;
    end
  end

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Decisions stand until the next bit, so they are read after the bit
  task automatic send_check(input logic mid, input logic trans);
    tx_u.send_bit(mid, trans);
    step(1);
    nbits++;
    // One reference pulse per change of the regenerated bit
    if (mid != prev_bit) begin
      ref_exp++;
    end
    if (nbits > 1) begin
      check({early, late}, {prev_bit != mid && trans == prev_bit, prev_bit != mid && trans == mid});
    end
    check(data, mid);
    // Line already shows the inverse, so the error pulse is up
    check(lin_err, 1'b1);
    prev_bit = mid;
  endtask : send_check

  task automatic wait_sel(input logic v, input int bound);
    int n;
    n = 0;
    while (psel !== v && n < bound) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check({fsel, psel}, {~v, v});
    if (psel !== v) begin
      summarize();
    end
  endtask : wait_sel

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(10);
    rst_n_i = 1'b1;
    acq_en = 1'b1;
    step(4);
    check({fsel, psel, locked, early, late, data_valid}, 16'h0020);
    for (int i = 0; i < 8; i++) begin
      send_check(i[2], 1'b0);
      send_check(i[0], i[1]);
    end
    for (int i = 0; i < 40; i++) begin
      rnd = $random(seed);
      send_check(rnd[0], rnd[1]);
    end
    check(valid_seen, nbits - 1);
    check(ref_seen, ref_exp);
    $display("test decision done");
    freq_lock = 1'b1;
    phase_lock = 1'b1;
    step(60);
    check(psel, 1'b0);
    wait_sel(1'b1, 40);
    step(2);
    check(locked, 1'b1);
    phase_lock = 1'b0;
    step(20);
    check(psel, 1'b1);
    // lock loss falls back to frequency loop
    wait_sel(1'b0, 40);
    wait_sel(1'b1, 100);
    // frequency loss while phase loop drives
    freq_lock = 1'b0;
    wait_sel(1'b0, 40);
    step(80);
    check(psel, 1'b0);
    acq_en = 1'b0;
    step(3);
    check({fsel, psel, locked}, 16'h0004);
    $display("test acquisition done");
    summarize();
  end
endmodule : cdr_phase_decision_and_acquisition_bench
